/* File: hdl/ocg_regs.vh */
// register map, field layout and timing constants of the clock generator control block
`ifndef OCG_REGS_VH
`define OCG_REGS_VH

// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define OCG_ADDR_SLOW_CFG   32'h0ffffd50
`define OCG_ADDR_MAIN_OSC   32'h0ffffc20
`define OCG_ADDR_MAIN_PLL   32'h0ffffc28
`define OCG_ADDR_USB_CLK    32'h0ffffc1c
`define OCG_ADDR_MCK        32'h0ffffc30
`define OCG_ADDR_STATUS     32'h0ffffc68

// ---------------------------------------------------------------
// slow clock configuration fields
// ---------------------------------------------------------------
`define OCG_SC_RC_EN        0
`define OCG_SC_XTAL_EN      1
`define OCG_SC_BYPASS       2
`define OCG_SC_SELECT       3
`define OCG_SC_RESET        4'h1

// ---------------------------------------------------------------
// main oscillator fields
// ---------------------------------------------------------------
`define OCG_MO_EN           0
`define OCG_MO_BYPASS       1
`define OCG_MO_CNT_LSB      8
`define OCG_MO_CNT_MSB      15

// ---------------------------------------------------------------
// main pll fields
// ---------------------------------------------------------------
`define OCG_PL_DIV_LSB      0
`define OCG_PL_DIV_MSB      7
`define OCG_PL_CNT_LSB      8
`define OCG_PL_CNT_MSB      13
`define OCG_PL_MUL_LSB      16
`define OCG_PL_MUL_MSB      23

// ---------------------------------------------------------------
// usb clock, master clock and status fields
// ---------------------------------------------------------------
`define OCG_UC_EN           16
`define OCG_UC_BIAS         24
`define OCG_UC_CNT_LSB      20
`define OCG_UC_CNT_MSB      23
`define OCG_MC_HALF         12
`define OCG_ST_MAIN_STABLE  0
`define OCG_ST_PLL_LOCKED   1
`define OCG_ST_USB_LOCKED   6
`define OCG_ST_SEL_BUSY     7

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define OCG_CORE_HZ         25000000
`define OCG_SLOW_HZ         32768
`define OCG_SLOW_RATIO      ((`OCG_CORE_HZ + `OCG_SLOW_HZ / 2) / `OCG_SLOW_HZ)
`define OCG_SLOW_DIV8       8
`define OCG_USB_MULT        6'h28
`define OCG_RESP_OKAY       2'h0
`define OCG_RESP_SLVERR     2'h2

`endif

/* File: hdl/ocg_tick_div.v */
// enable divider: one pulse of tick_o for every RATIO pulses of en_i
`timescale 1ns/100ps
`default_nettype none
module ocg_tick_div #(
  parameter integer RATIO = 8
) (
  input wire clk_i,
  input wire nrst_i,
  input wire en_i,
  output wire tick_o
);
  reg [15:0] cnt_q;

  assign tick_o = en_i && (cnt_q == RATIO[15:0] - 16'h0001);

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      cnt_q <= 16'h0000;
    end else if (tick_o) begin
      cnt_q <= 16'h0000;
    end else if (en_i) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
endmodule // ocg_tick_div
`default_nettype wire

/* File: hdl/ocg_countdown.v */
// startup / lock down-counter: load clears the flag, flag sets on the first tick after count reaches zero
`timescale 1ns/100ps
`default_nettype none
module ocg_countdown #(
  parameter integer W = 8
) (
  input wire clk_i,
  input wire nrst_i,
  input wire clr_i,
  input wire load_i,
  input wire [W-1:0] load_val_i,
  input wire tick_i,
  output reg done_o
);
  reg [W-1:0] cnt_q;
  reg run_q;

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      cnt_q <= {W{1'b0}};
      run_q <= 1'b0;
      done_o <= 1'b0;
    end else if (clr_i) begin
      run_q <= 1'b0;
      done_o <= 1'b0;
    end else if (load_i) begin
      cnt_q <= load_val_i;
      run_q <= 1'b1;
      done_o <= 1'b0;
    end else if (run_q && tick_i) begin
      if (cnt_q == {W{1'b0}}) begin
        run_q <= 1'b0;
        done_o <= 1'b1;
      end else begin
        cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // ocg_countdown
`default_nettype wire

/* File: hdl/ocg_top.v */
// clock generator control: slow clock select, main oscillator, main and usb pll, axi4-lite registers
//
// How it works
// - selector 0 gives rc, 1 gives crystal
// - backup reset: rc on, crystal off, select 0
// - bypass bit routes external slow input pin
// - enable bits switch each slow oscillator
// - slow configuration reset only by backup reset
// - selector change resynchronised within two slow cycles
// - main oscillator disabled after reset
// - clearing main enable clears stable flag
// - enable write loads startup count, slow/8
// - startup count zero sets stable flag
// - divider zero forces pll output low
// - pll ratio is multiplier plus one over divider
// - multiplier zero disables pll, nonzero enables
// - pll change reloads lock count per slow cycle
// - half bit divides pll output by two
// - usb pll multiplies main clock by forty
// - usb enable loads lock count, slow/8
`timescale 1ns/100ps
`default_nettype none
`include "ocg_regs.vh"
module ocg_top #(
  parameter integer SLOW_RATIO = `OCG_SLOW_RATIO
) (
  input wire CORE_CLK_I,
  input wire NRST_I,
  input wire BACKUP_NRST_I,
  input wire [31:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output wire S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output wire S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [31:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output wire S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY,
  input wire RC_OSC_CLK_I,
  input wire SLOW_CRYSTAL_CLK_I,
  input wire SLOW_CRYSTAL_INPUT_I,
  output reg SLOW_CLK_O,
  output wire RC_OSC_ENABLE_O,
  output wire SLOW_CRYSTAL_ENABLE_O,
  output wire SLOW_CRYSTAL_BYPASS_O,
  output wire SLOW_SOURCE_SELECT_O,
  output wire MAIN_OSC_ENABLE_O,
  output wire MAIN_OSC_BYPASS_O,
  output wire MAIN_OSC_STABLE_O,
  output wire [7:0] MAIN_PLL_DIVIDER_O,
  output wire [7:0] MAIN_PLL_MULTIPLIER_O,
  output wire MAIN_PLL_RUN_O,
  output wire MAIN_PLL_HALF_O,
  output wire MAIN_PLL_LOCKED_O,
  output wire [5:0] USB_PLL_MULT_O,
  output wire USB_PLL_ENABLE_O,
  output wire USB_PLL_LOCKED_O,
  output wire USB_BIAS_ENABLE_O
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg [3:0] slow_cfg_q;
  reg [31:0] main_osc_q;
  reg [31:0] main_pll_q;
  reg [31:0] usb_clk_q;
  reg [31:0] mck_q;
  reg sel_stage_q;
  reg sel_applied_q;
  reg aw_held_q;
  reg w_held_q;
  reg [31:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg [31:0] rd_data_d;
  reg rd_hit_d;
  reg wr_hit_d;
  wire wr_go;
  wire [31:0] wr_val;
  wire slow_tick;
  wire slow8_tick;
  wire mo_write;
  wire pl_write;
  wire uc_write;
  wire [31:0] status;
  wire [31:0] aw_word = {aw_addr_q[31:2], 2'b00};

  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] strb;
    integer i;
    begin
      merge = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = new_v[i*8 +: 8];
        end
      end
    end
  endfunction

  // ---------------------------------------------------------------
  // axi4-lite write channel
  // ---------------------------------------------------------------
  assign S_AXI_AWREADY = !aw_held_q && !S_AXI_BVALID;
  assign S_AXI_WREADY = !w_held_q && !S_AXI_BVALID;
  assign wr_go = aw_held_q && w_held_q && !S_AXI_BVALID;

  always @(posedge CORE_CLK_I) begin
    if (!NRST_I) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 32'h00000000;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `OCG_RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held_q <= 1'b1;
        w_data_q <= S_AXI_WDATA;
        w_strb_q <= S_AXI_WSTRB;
      end
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_hit_d ? `OCG_RESP_OKAY : `OCG_RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  always @* begin
    wr_hit_d = (aw_word == `OCG_ADDR_SLOW_CFG) || (aw_word == `OCG_ADDR_MAIN_OSC) ||
               (aw_word == `OCG_ADDR_MAIN_PLL) || (aw_word == `OCG_ADDR_USB_CLK) ||
               (aw_word == `OCG_ADDR_MCK);
  end
  assign mo_write = wr_go && (aw_word == `OCG_ADDR_MAIN_OSC);
  assign pl_write = wr_go && (aw_word == `OCG_ADDR_MAIN_PLL);
  assign uc_write = wr_go && (aw_word == `OCG_ADDR_USB_CLK);

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  assign wr_val = merge(main_osc_q, w_data_q, w_strb_q);
  // slow configuration sits in the backup domain: only the backup reset returns it to its default (rc on)
  always @(posedge CORE_CLK_I) begin
    if (!BACKUP_NRST_I) begin
      slow_cfg_q <= `OCG_SC_RESET;
    end else if (wr_go && (aw_word == `OCG_ADDR_SLOW_CFG) && w_strb_q[0]) begin
      slow_cfg_q <= w_data_q[3:0];
    end
  end

  always @(posedge CORE_CLK_I) begin
    if (!NRST_I) begin
      main_osc_q <= 32'h00000000;
      main_pll_q <= 32'h00000000;
      usb_clk_q <= 32'h00000000;
      mck_q <= 32'h00000000;
    end else begin
      if (mo_write) main_osc_q <= merge(main_osc_q, w_data_q, w_strb_q);
      if (pl_write) main_pll_q <= merge(main_pll_q, w_data_q, w_strb_q);
      if (uc_write) usb_clk_q <= merge(usb_clk_q, w_data_q, w_strb_q);
      if (wr_go && (aw_word == `OCG_ADDR_MCK)) mck_q <= merge(mck_q, w_data_q, w_strb_q);
    end
  end

  // ---------------------------------------------------------------
  // slow clock timebase
  // ---------------------------------------------------------------
  ocg_tick_div #(.RATIO(SLOW_RATIO)) u_slow_div (
    .clk_i(CORE_CLK_I),
    .nrst_i(NRST_I),
    .en_i(1'b1),
    .tick_o(slow_tick)
  );

  ocg_tick_div #(.RATIO(`OCG_SLOW_DIV8)) u_slow8_div (
    .clk_i(CORE_CLK_I),
    .nrst_i(NRST_I),
    .en_i(slow_tick),
    .tick_o(slow8_tick)
  );

  // ---------------------------------------------------------------
  // slow clock source selection
  // ---------------------------------------------------------------
  // selector moves through two slow-tick stages before it switches the mux
  always @(posedge CORE_CLK_I) begin
    if (!BACKUP_NRST_I) begin
      sel_stage_q <= 1'b0;
      sel_applied_q <= 1'b0;
    end else if (slow_tick) begin
      sel_stage_q <= slow_cfg_q[`OCG_SC_SELECT];
      sel_applied_q <= sel_stage_q;
    end
  end

  always @* begin
    if (!sel_applied_q) begin
      SLOW_CLK_O = RC_OSC_CLK_I;
    end else if (slow_cfg_q[`OCG_SC_BYPASS]) begin
      SLOW_CLK_O = SLOW_CRYSTAL_INPUT_I;
    end else begin
      SLOW_CLK_O = SLOW_CRYSTAL_CLK_I;
    end
  end

  assign RC_OSC_ENABLE_O = slow_cfg_q[`OCG_SC_RC_EN];
  assign SLOW_CRYSTAL_ENABLE_O = slow_cfg_q[`OCG_SC_XTAL_EN];
  assign SLOW_CRYSTAL_BYPASS_O = slow_cfg_q[`OCG_SC_BYPASS];
  assign SLOW_SOURCE_SELECT_O = sel_applied_q;

  // ---------------------------------------------------------------
  // main oscillator startup
  // ---------------------------------------------------------------
  ocg_countdown #(.W(8)) u_main_osc_cnt (
    .clk_i(CORE_CLK_I),
    .nrst_i(NRST_I),
    .clr_i(mo_write && !wr_val[`OCG_MO_EN]),
    .load_i(mo_write && wr_val[`OCG_MO_EN]),
    .load_val_i(wr_val[`OCG_MO_CNT_MSB:`OCG_MO_CNT_LSB]),
    .tick_i(slow8_tick),
    .done_o(MAIN_OSC_STABLE_O)
  );

  assign MAIN_OSC_ENABLE_O = main_osc_q[`OCG_MO_EN];
  assign MAIN_OSC_BYPASS_O = main_osc_q[`OCG_MO_BYPASS];

  // ---------------------------------------------------------------
  // main pll
  // ---------------------------------------------------------------
  wire [31:0] pl_new = merge(main_pll_q, w_data_q, w_strb_q);
  wire pl_new_mul_nz = pl_new[`OCG_PL_MUL_MSB:`OCG_PL_MUL_LSB] != 8'h00;
  wire pl_changed = (pl_new[`OCG_PL_MUL_MSB:`OCG_PL_MUL_LSB] !=
                     main_pll_q[`OCG_PL_MUL_MSB:`OCG_PL_MUL_LSB]) ||
                    (pl_new[`OCG_PL_DIV_MSB:`OCG_PL_DIV_LSB] !=
                     main_pll_q[`OCG_PL_DIV_MSB:`OCG_PL_DIV_LSB]);

  ocg_countdown #(.W(6)) u_main_pll_cnt (
    .clk_i(CORE_CLK_I),
    .nrst_i(NRST_I),
    .clr_i(pl_write && !pl_new_mul_nz),
    .load_i(pl_write && pl_changed),
    .load_val_i(pl_new[`OCG_PL_CNT_MSB:`OCG_PL_CNT_LSB]),
    .tick_i(slow_tick),
    .done_o(MAIN_PLL_LOCKED_O)
  );

  // analog pll output = source * (multiplier + 1) / divider
  assign MAIN_PLL_DIVIDER_O = main_pll_q[`OCG_PL_DIV_MSB:`OCG_PL_DIV_LSB];
  assign MAIN_PLL_MULTIPLIER_O = main_pll_q[`OCG_PL_MUL_MSB:`OCG_PL_MUL_LSB];
  assign MAIN_PLL_RUN_O = (MAIN_PLL_MULTIPLIER_O != 8'h00) &&
                          (MAIN_PLL_DIVIDER_O != 8'h00);
  assign MAIN_PLL_HALF_O = mck_q[`OCG_MC_HALF];

  // ---------------------------------------------------------------
  // usb pll
  // ---------------------------------------------------------------
  wire [31:0] uc_new = merge(usb_clk_q, w_data_q, w_strb_q);

  ocg_countdown #(.W(4)) u_usb_pll_cnt (
    .clk_i(CORE_CLK_I),
    .nrst_i(NRST_I),
    .clr_i(uc_write && !uc_new[`OCG_UC_EN]),
    .load_i(uc_write && uc_new[`OCG_UC_EN] && !usb_clk_q[`OCG_UC_EN]),
    .load_val_i(uc_new[`OCG_UC_CNT_MSB:`OCG_UC_CNT_LSB]),
    .tick_i(slow8_tick),
    .done_o(USB_PLL_LOCKED_O)
  );

  assign USB_PLL_MULT_O = `OCG_USB_MULT;
  assign USB_PLL_ENABLE_O = usb_clk_q[`OCG_UC_EN];
  // bias follows software, which waits for the lock flag first
  assign USB_BIAS_ENABLE_O = usb_clk_q[`OCG_UC_BIAS];

  // ---------------------------------------------------------------
  // axi4-lite read channel
  // ---------------------------------------------------------------
  assign status = ({31'h00000000, MAIN_OSC_STABLE_O} << `OCG_ST_MAIN_STABLE) |
                  ({31'h00000000, MAIN_PLL_LOCKED_O} << `OCG_ST_PLL_LOCKED) |
                  ({31'h00000000, USB_PLL_LOCKED_O} << `OCG_ST_USB_LOCKED) |
                  ({31'h00000000, sel_applied_q != slow_cfg_q[`OCG_SC_SELECT]}
                   << `OCG_ST_SEL_BUSY);

  assign S_AXI_ARREADY = !S_AXI_RVALID;

  always @* begin
    rd_hit_d = 1'b1;
    case ({S_AXI_ARADDR[31:2], 2'b00})
      `OCG_ADDR_SLOW_CFG: rd_data_d = {28'h0000000, slow_cfg_q};
      `OCG_ADDR_MAIN_OSC: rd_data_d = main_osc_q;
      `OCG_ADDR_MAIN_PLL: rd_data_d = main_pll_q;
      `OCG_ADDR_USB_CLK: rd_data_d = usb_clk_q;
      `OCG_ADDR_MCK: rd_data_d = mck_q;
      `OCG_ADDR_STATUS: rd_data_d = status;
      default: begin
        rd_data_d = 32'h00000000;
        rd_hit_d = 1'b0;
      end
    endcase
  end

  always @(posedge CORE_CLK_I) begin
    if (!NRST_I) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= `OCG_RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_data_d;
      S_AXI_RRESP <= rd_hit_d ? `OCG_RESP_OKAY : `OCG_RESP_SLVERR;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end
endmodule // ocg_top
`default_nettype wire

/* File: dv/ocg_top_properties.sv */
// port-level assertions for the clock generator control block
`timescale 1ns/100ps
`default_nettype none
module ocg_top_properties #(
  parameter integer SLOW_RATIO = 4
) (
  input wire logic CORE_CLK_I,
  input wire logic NRST_I,
  input wire logic BACKUP_NRST_I,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic RC_OSC_CLK_I,
  input wire logic SLOW_CRYSTAL_CLK_I,
  input wire logic SLOW_CRYSTAL_INPUT_I,
  input wire logic SLOW_CLK_O,
  input wire logic RC_OSC_ENABLE_O,
  input wire logic SLOW_CRYSTAL_ENABLE_O,
  input wire logic SLOW_CRYSTAL_BYPASS_O,
  input wire logic SLOW_SOURCE_SELECT_O,
  input wire logic MAIN_OSC_ENABLE_O,
  input wire logic MAIN_OSC_STABLE_O,
  input wire logic [7:0] MAIN_PLL_DIVIDER_O,
  input wire logic [7:0] MAIN_PLL_MULTIPLIER_O,
  input wire logic MAIN_PLL_RUN_O,
  input wire logic MAIN_PLL_LOCKED_O,
  input wire logic [5:0] USB_PLL_MULT_O,
  input wire logic USB_PLL_ENABLE_O,
  input wire logic USB_PLL_LOCKED_O
);
  // ----------------------------------------
  // longest startup wait: 255 plus margin, slow/8 ticks
  // ----------------------------------------
  localparam int LIM = 257 * 8 * SLOW_RATIO + 4;
  logic [31:0] wait_q;
  logic [31:0] wait_d;
  assign wait_d = (MAIN_OSC_ENABLE_O && !MAIN_OSC_STABLE_O) ? wait_q + 32'h1 : 32'h0;
  always_ff @(posedge CORE_CLK_I) begin
    if (!NRST_I) wait_q <= 32'h0;
    else wait_q <= wait_d;
  end
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!NRST_I);
  sequence wr_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence osc_start;
    $rose(MAIN_OSC_ENABLE_O);
  endsequence
  sequence pll_move;
    $changed(MAIN_PLL_MULTIPLIER_O) || $changed(MAIN_PLL_DIVIDER_O);
  endsequence
  a_write_answer: assert property (wr_taken |-> ##2 S_AXI_BVALID)
    else $error("write response late");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read response late");
  a_slow_route: assert property (SLOW_CLK_O == (!SLOW_SOURCE_SELECT_O ? RC_OSC_CLK_I :
    SLOW_CRYSTAL_BYPASS_O ? SLOW_CRYSTAL_INPUT_I : SLOW_CRYSTAL_CLK_I))
    else $error("slow clock routed wrongly");
  a_backup_default: assert property (!BACKUP_NRST_I |=> RC_OSC_ENABLE_O &&
    !SLOW_CRYSTAL_ENABLE_O && !SLOW_CRYSTAL_BYPASS_O && !SLOW_SOURCE_SELECT_O)
    else $error("slow config not at default");
  a_osc_off_flag: assert property (!MAIN_OSC_ENABLE_O |-> !MAIN_OSC_STABLE_O)
    else $error("stable while oscillator off");
  a_osc_start_clear: assert property (osc_start |-> !MAIN_OSC_STABLE_O)
    else $error("stable not cleared on enable");
  a_osc_wait_bound: assert property (wait_q <= LIM)
    else $error("stable flag never set");
  a_pll_run: assert property (MAIN_PLL_RUN_O == (|MAIN_PLL_MULTIPLIER_O && |MAIN_PLL_DIVIDER_O))
    else $error("pll run wrong");
  a_pll_move_unlock: assert property (pll_move |-> !MAIN_PLL_LOCKED_O)
    else $error("lock kept over change");
  a_pll_off_unlock: assert property (MAIN_PLL_MULTIPLIER_O == 8'h00 |-> !MAIN_PLL_LOCKED_O)
    else $error("lock while pll off");
  a_usb_mult_fixed: assert property (USB_PLL_MULT_O == 6'h28)
    else $error("usb multiplier wrong");
  a_usb_off_unlock: assert property (!USB_PLL_ENABLE_O |-> !USB_PLL_LOCKED_O)
    else $error("usb lock while off");
endmodule // ocg_top_properties
`default_nettype wire

/* File: dv/ocg_top_tb_top.sv */
// self-checking bench for the clock generator control block
`timescale 1ns/100ps
`default_nettype none
`include "ocg_regs.vh"
module ocg_top_tb_top;
  typedef struct {logic [31:0] a, d, m, e; logic [1:0] wr, rr;} ocg_row_t;
  logic clk = 1'b0, nrst = 1'b0, bnrst = 1'b0;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0, d;
  logic [2:0] sc = 3'h0;
  logic [1:0] r;
  wire awr, wrr, bv, arr, rv, slow, rce, xte, byp, sel, moe, mob, mos, run, half, plk, ue, ulk, ub;
  wire [1:0] bresp, rresp;
  wire [31:0] rdat;
  wire [7:0] div, mul;
  wire [5:0] umul;
  int fail_count = 0, n_checks = 0, n;
  ocg_row_t rows [7] = '{
    '{`OCG_ADDR_SLOW_CFG, 32'hfffffff5, 32'h0000000f, 32'h00000005, 2'h0, 2'h0},
    '{`OCG_ADDR_MAIN_OSC, 32'h00000302, 32'h0000ff03, 32'h00000302, 2'h0, 2'h0},
    '{`OCG_ADDR_MAIN_PLL, 32'h00030201, 32'h00ff3fff, 32'h00030201, 2'h0, 2'h0},
    '{`OCG_ADDR_USB_CLK, 32'h00100000, 32'h01f10000, 32'h00100000, 2'h0, 2'h0},
    '{`OCG_ADDR_MCK, 32'h00001000, 32'h00001000, 32'h00001000, 2'h0, 2'h0},
    '{`OCG_ADDR_STATUS, 32'hffffffff, 32'h000000c3, 32'h00000002, 2'h2, 2'h0},
    '{32'h0ffffc00, 32'h00001234, 32'hffffffff, 32'h00000000, 2'h2, 2'h2}};
  ocg_top #(.SLOW_RATIO(4)) DUT (
    .CORE_CLK_I(clk), .NRST_I(nrst), .BACKUP_NRST_I(bnrst), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wrr), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry),
    .RC_OSC_CLK_I(sc[0]), .SLOW_CRYSTAL_CLK_I(sc[1]), .SLOW_CRYSTAL_INPUT_I(sc[2]),
    .SLOW_CLK_O(slow), .RC_OSC_ENABLE_O(rce), .SLOW_CRYSTAL_ENABLE_O(xte),
    .SLOW_CRYSTAL_BYPASS_O(byp), .SLOW_SOURCE_SELECT_O(sel), .MAIN_OSC_ENABLE_O(moe),
    .MAIN_OSC_BYPASS_O(mob), .MAIN_OSC_STABLE_O(mos), .MAIN_PLL_DIVIDER_O(div),
    .MAIN_PLL_MULTIPLIER_O(mul), .MAIN_PLL_RUN_O(run), .MAIN_PLL_HALF_O(half),
    .MAIN_PLL_LOCKED_O(plk), .USB_PLL_MULT_O(umul), .USB_PLL_ENABLE_O(ue),
    .USB_PLL_LOCKED_O(ulk), .USB_BIAS_ENABLE_O(ub));
  // ----------------------------------------
  // clock, slow clock candidates, bus tasks
  // ----------------------------------------
  initial forever #20 clk = ~clk;
  always @(posedge clk) sc <= sc + 3'h1;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chb(input logic got, input logic exp);
    chk(32'(got), 32'(exp));
  endtask
  task automatic axw(input logic [31:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    @(posedge clk);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    for (int i = 0; i < 200; i++) begin
      @(negedge clk);
      ta = awv && awr;
      tw = wv && wrr;
      tb = bv;
      r = bresp;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      if (tb) begin
        bry <= 1'b0;
        break;
      end
    end
    if (tb !== 1'b1) fail_count++;
    @(negedge clk);
  endtask
  task automatic axr(input logic [31:0] a);
    logic ta, tr;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    for (int i = 0; i < 200; i++) begin
      @(negedge clk);
      ta = arv && arr;
      tr = rv;
      d = rdat;
      r = rresp;
      @(posedge clk);
      if (ta) arv <= 1'b0;
      if (tr) begin
        rry <= 1'b0;
        break;
      end
    end
    if (tr !== 1'b1) fail_count++;
  endtask
  // counts cycles until the chosen flag is seen high (for s 4, until sel is seen low)
  task automatic wt(input int s);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (n < 2000 && !(s == 0 ? mos : s == 1 ? plk : s == 2 ? ulk : s == 3 ? sel : !sel));
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #(40 * 20000);
    fail_count++;
    conclude();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    bnrst <= 1'b1;
    @(negedge clk);
    chb(rce & !xte & !sel, 1'b1);
    chb(moe | mos, 1'b0);
    chk(32'({div, run}), 32'h0);
    chk(32'(umul), 32'h28);
    $display("test reset done");
    foreach (rows[i]) begin
      axw(rows[i].a, rows[i].d);
      chk(32'(r), 32'(rows[i].wr));
      axr(rows[i].a);
      chk(32'(r), 32'(rows[i].rr));
      chk(d & rows[i].m, rows[i].e);
    end
    chb(half & mob & !moe & byp & rce & run, 1'b1);
    chk(32'({div, mul}), 32'h0103);
    $display("test table done");
    axw(`OCG_ADDR_MAIN_OSC, 32'h00000301);
    chb(moe & !mos, 1'b1);
    wt(0);
    chb(n >= 94 && n <= 130, 1'b1);
    axr(`OCG_ADDR_STATUS);
    chb(d[0], 1'b1);
    axw(`OCG_ADDR_MAIN_OSC, 32'h00000300);
    chb(mos, 1'b0);
    $display("test main oscillator done");
    axw(`OCG_ADDR_MAIN_PLL, 32'h00040501);
    chb(plk, 1'b0);
    wt(1);
    chb(n >= 19 && n <= 25, 1'b1);
    axw(`OCG_ADDR_MAIN_PLL, 32'h00040502);
    chb(!plk & run, 1'b1);
    axw(`OCG_ADDR_MAIN_PLL, 32'h00000502);
    chb(plk | run, 1'b0);
    axw(`OCG_ADDR_MAIN_PLL, 32'h00040500);
    chb(run, 1'b0);
    $display("test main pll done");
    axw(`OCG_ADDR_USB_CLK, 32'h00210000);
    chb(ue & !ulk, 1'b1);
    wt(2);
    chb(n >= 62 && n <= 97, 1'b1);
    axw(`OCG_ADDR_USB_CLK, 32'h01210000);
    chb(ub & ulk, 1'b1);
    $display("test usb pll done");
    axw(`OCG_ADDR_SLOW_CFG, 32'h00000003);
    axw(`OCG_ADDR_SLOW_CFG, 32'h0000000b);
    wt(3);
    chb(n <= 20, 1'b1);
    repeat (8) begin
      @(negedge clk);
      chb(slow, sc[1]);
    end
    axw(`OCG_ADDR_SLOW_CFG, 32'h0000000a);
    chb(!rce & xte, 1'b1);
    axw(`OCG_ADDR_SLOW_CFG, 32'h0000000e);
    repeat (8) begin
      @(negedge clk);
      chb(slow, sc[2]);
    end
    axw(`OCG_ADDR_SLOW_CFG, 32'h0000000c);
    chb(byp & !xte & sel, 1'b1);
    axw(`OCG_ADDR_SLOW_CFG, 32'h0000000d);
    axw(`OCG_ADDR_SLOW_CFG, 32'h00000005);
    wt(4);
    chb(n <= 20, 1'b1);
    repeat (8) begin
      @(negedge clk);
      chb(slow, sc[0]);
    end
    chb(rce & !xte, 1'b1);
    $display("test slow select done");
    @(posedge clk);
    nrst <= 1'b0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    axr(`OCG_ADDR_SLOW_CFG);
    chk(d & 32'hf, 32'h5);
    chb(moe | ue | plk, 1'b0);
    bnrst <= 1'b0;
    repeat (2) @(posedge clk);
    bnrst <= 1'b1;
    axr(`OCG_ADDR_SLOW_CFG);
    chk(d & 32'hf, 32'h1);
    $display("test resets done");
    conclude();
  end
endmodule // ocg_top_tb_top
bind ocg_top ocg_top_properties #(.SLOW_RATIO(SLOW_RATIO)) u_props (
  .CORE_CLK_I(CORE_CLK_I), .NRST_I(NRST_I), .BACKUP_NRST_I(BACKUP_NRST_I),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID), .RC_OSC_CLK_I(RC_OSC_CLK_I),
  .SLOW_CRYSTAL_CLK_I(SLOW_CRYSTAL_CLK_I), .SLOW_CRYSTAL_INPUT_I(SLOW_CRYSTAL_INPUT_I),
  .SLOW_CLK_O(SLOW_CLK_O), .RC_OSC_ENABLE_O(RC_OSC_ENABLE_O),
  .SLOW_CRYSTAL_ENABLE_O(SLOW_CRYSTAL_ENABLE_O), .SLOW_CRYSTAL_BYPASS_O(SLOW_CRYSTAL_BYPASS_O),
  .SLOW_SOURCE_SELECT_O(SLOW_SOURCE_SELECT_O), .MAIN_OSC_ENABLE_O(MAIN_OSC_ENABLE_O),
  .MAIN_OSC_STABLE_O(MAIN_OSC_STABLE_O), .MAIN_PLL_DIVIDER_O(MAIN_PLL_DIVIDER_O),
  .MAIN_PLL_MULTIPLIER_O(MAIN_PLL_MULTIPLIER_O), .MAIN_PLL_RUN_O(MAIN_PLL_RUN_O),
  .MAIN_PLL_LOCKED_O(MAIN_PLL_LOCKED_O), .USB_PLL_MULT_O(USB_PLL_MULT_O),
  .USB_PLL_ENABLE_O(USB_PLL_ENABLE_O), .USB_PLL_LOCKED_O(USB_PLL_LOCKED_O));
`default_nettype wire
